// ---- core/wsod_top.sv ----
// wake status latch, off-delay timer and their axi4-lite registers
//
// How it works
// - a fall on the first uart receive line sets status bit 0 until read.
// - a fall on the second uart receive line sets status bit 1 until read.
// - a ring indicator fall sets status bit 3, cleared by reading status.
// - an infrared wake event sets status bit 5, cleared by reading status.
// - flags show events since last clear; only enabled events request power.
// - the wake status register resets to all zeros.
// - delay lasts (code+1) times 500 ms, at most 10 ms longer.
// - delay register resets to zero, upper two bits reserved.
// - delay starts on a button press with off-allow and delayed-off both set.
// - the off-allow bit, enable bit 7, resets to one.
// - an enable bit of zero keeps its event from requesting power.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wsod_top #(
    parameter int STEP_CYCLES = wsod_pkg::DELAY_STEP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wsod_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [wsod_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wsod_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [wsod_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire wsod_pkg::wsod_pins_t wake_pins,
    input wire logic button_in,
    output logic power_request_n,
    output logic irq
);
    localparam int AW = wsod_pkg::ADDR_W;
    localparam int RW = wsod_pkg::REG_W;
    localparam int WN = wsod_pkg::WAKE_N;

    logic [RW-1:0] enable_two;
    logic [RW-1:0] delay_reg;
    logic delayed_off_select;
    logic [wsod_pkg::IRQ_W-1:0] irq_status;
    logic [wsod_pkg::IRQ_W-1:0] irq_mask;
    wsod_pkg::wsod_status_t status;
    // read back on the control register, so declared ahead of the read mux
    logic timer_busy;

    // ---------------- wake sources ----------------
    logic [WN-1:0] wake_level_n;
    logic [WN-1:0] wake_clear;
    logic [WN-1:0] wake_set;
    logic [WN-1:0] wake_flag;
    logic [WN-1:0] wake_enable;
    logic wake_hit;

    // infrared event is active high, so it is inverted into the fall catcher
    assign wake_level_n = {~wake_pins.cir_wake_event,
                           wake_pins.ring_indicator_pin_n,
                           wake_pins.uart_second_rx,
                           wake_pins.uart_first_rx};

    wsod_edge_latch #(
        .N(WN)
    ) u_latch (
        .aclk(aclk),
        .aresetn(aresetn),
        .level_n(wake_level_n),
        .clear(wake_clear),
        .set_pulse(wake_set),
        .flag(wake_flag)
    );

    always_comb begin
        status = wsod_pkg::WAKE_STATUS_RESET;
        status.uart_first_rx_wake_flag = wake_flag[0];
        status.uart_second_rx_wake_flag = wake_flag[1];
        status.ring_wake_flag = wake_flag[2];
        status.infrared_wake_flag = wake_flag[3];
    end

    assign wake_enable = {enable_two[wsod_pkg::BIT_INFRARED],
                          enable_two[wsod_pkg::BIT_RING],
                          enable_two[wsod_pkg::BIT_RX_SECOND],
                          enable_two[wsod_pkg::BIT_RX_FIRST]};
    assign wake_hit = |(wake_set & wake_enable);

    // ---------------- write channels ----------------
    logic aw_have;
    logic w_have;
    logic [AW-1:0] aw_addr;
    logic [wsod_pkg::DATA_W-1:0] w_data;
    logic w_lane0;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_ok;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    // write happens once both halves are held and the last answer is gone
    assign wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign wr_idx = aw_addr[AW-1:2];

    always_comb begin
        case (wr_idx)
            wsod_pkg::IDX_ENABLE_TWO,
            wsod_pkg::IDX_WAKE_STATUS_TWO,
            wsod_pkg::IDX_OFF_DELAY,
            wsod_pkg::IDX_CONTROL,
            wsod_pkg::IDX_IRQ_STATUS,
            wsod_pkg::IDX_IRQ_MASK: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_have <= 1'b0;
            aw_addr <= '0;
        end else if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else begin
            if (wr_fire) begin
                aw_have <= 1'b0;
            end
            s_axi_awready <= !aw_have && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_have <= 1'b0;
            w_data <= '0;
            w_lane0 <= 1'b0;
        end else if (w_take) begin
            s_axi_wready <= 1'b0;
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
        end else begin
            if (wr_fire) begin
                w_have <= 1'b0;
            end
            s_axi_wready <= !w_have && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= wsod_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? wsod_pkg::RESP_OKAY : wsod_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // registers live in byte lane 0; other lanes are ignored
    logic wr_reg;
    assign wr_reg = wr_fire && w_lane0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_two <= wsod_pkg::ENABLE_TWO_RESET;
        end else if (wr_reg && wr_idx == wsod_pkg::IDX_ENABLE_TWO) begin
            enable_two <= w_data[RW-1:0] & wsod_pkg::ENABLE_TWO_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            delay_reg <= wsod_pkg::OFF_DELAY_RESET;
        end else if (wr_reg && wr_idx == wsod_pkg::IDX_OFF_DELAY) begin
            // reserved upper bits never store
            delay_reg <= w_data[RW-1:0] & wsod_pkg::OFF_DELAY_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            delayed_off_select <= 1'b0;
            irq_mask <= '0;
        end else if (wr_reg) begin
            if (wr_idx == wsod_pkg::IDX_CONTROL) begin
                delayed_off_select <= w_data[wsod_pkg::CTRL_SEL_BIT];
            end
            if (wr_idx == wsod_pkg::IDX_IRQ_MASK) begin
                irq_mask <= w_data[wsod_pkg::IRQ_W-1:0];
            end
        end
    end

    // ---------------- read channel ----------------
    logic ar_take;
    logic [7:0] rd_idx;
    logic [RW-1:0] rd_byte;
    logic rd_ok;
    logic rd_status_hit;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[AW-1:2];
    assign rd_status_hit = ar_take && rd_idx == wsod_pkg::IDX_WAKE_STATUS_TWO;
    // the read returns the flags as they stood, then drops them
    assign wake_clear = rd_status_hit ? '1 : '0;

    always_comb begin
        rd_byte = '0;
        rd_ok = 1'b1;
        case (rd_idx)
            wsod_pkg::IDX_ENABLE_TWO: rd_byte = enable_two;
            wsod_pkg::IDX_WAKE_STATUS_TWO: rd_byte = status;
            wsod_pkg::IDX_OFF_DELAY: rd_byte = delay_reg;
            wsod_pkg::IDX_CONTROL: begin
                rd_byte[wsod_pkg::CTRL_SEL_BIT] = delayed_off_select;
                rd_byte[wsod_pkg::CTRL_POWER_BIT] = !power_request_n;
                rd_byte[wsod_pkg::CTRL_BUSY_BIT] = timer_busy;
            end
            wsod_pkg::IDX_IRQ_STATUS: rd_byte[wsod_pkg::IRQ_W-1:0] = irq_status;
            wsod_pkg::IDX_IRQ_MASK: rd_byte[wsod_pkg::IRQ_W-1:0] = irq_mask;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= wsod_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {{(wsod_pkg::DATA_W - RW){1'b0}}, rd_byte};
            s_axi_rresp <= rd_ok ? wsod_pkg::RESP_OKAY : wsod_pkg::RESP_SLVERR;
        end else begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    // ---------------- button and off delay ----------------
    logic button_prev;
    logic button_edge;
    logic timer_start;
    logic timer_expired;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            button_prev <= 1'b1; // a button held through reset is no press
        end else begin
            button_prev <= button_in;
        end
    end

    assign button_edge = button_in && !button_prev;
    assign timer_start = button_edge && enable_two[wsod_pkg::BIT_OFF_EN]
                         && delayed_off_select;

    wsod_delay_timer #(
        .CODE_W(wsod_pkg::DELAY_CODE_W),
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(timer_start),
        .code(delay_reg[wsod_pkg::DELAY_CODE_W-1:0]),
        .busy(timer_busy),
        .expired(timer_expired)
    );

    // a fresh enabled wake outranks an expiry in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_request_n <= 1'b1;
        end else if (wake_hit) begin
            power_request_n <= 1'b0;
        end else if (timer_expired) begin
            power_request_n <= 1'b1;
        end
    end

    // ---------------- interrupt ----------------
    logic [wsod_pkg::IRQ_W-1:0] irq_set;
    logic [wsod_pkg::IRQ_W-1:0] irq_w1c;

    always_comb begin
        irq_set = '0;
        irq_set[wsod_pkg::IRQ_WAKE_BIT] = |wake_set;
        irq_set[wsod_pkg::IRQ_EXPIRE_BIT] = timer_expired;
        irq_w1c = '0;
        if (wr_reg && wr_idx == wsod_pkg::IDX_IRQ_STATUS) begin
            irq_w1c = w_data[wsod_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_w1c) | irq_set;
            irq <= |(irq_status & irq_mask);
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_first_rx_sets;
        $fell(wake_pins.uart_first_rx) |=> status.uart_first_rx_wake_flag;
    endproperty
    a_first_rx_sets: assert property (p_first_rx_sets) else $error("rx1 flag missed");

    property p_second_rx_sets;
        $fell(wake_pins.uart_second_rx) |=> status.uart_second_rx_wake_flag;
    endproperty
    a_second_rx_sets: assert property (p_second_rx_sets) else $error("rx2 flag missed");

    property p_ring_sets;
        $fell(wake_pins.ring_indicator_pin_n) |=> status.ring_wake_flag;
    endproperty
    a_ring_sets: assert property (p_ring_sets) else $error("ring flag missed");

    property p_infrared_sets;
        $rose(wake_pins.cir_wake_event) |=> status.infrared_wake_flag;
    endproperty
    a_infrared_sets: assert property (p_infrared_sets) else $error("infrared flag missed");

    property p_read_clears;
        (rd_status_hit && wake_set == '0) |=> status == wsod_pkg::WAKE_STATUS_RESET;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

    property p_enabled_wakes;
        (|(wake_set & wake_enable)) |=> !power_request_n ##1 $stable(power_request_n) || $past(timer_expired);
    endproperty
    a_enabled_wakes: assert property (p_enabled_wakes) else $error("enabled wake ignored");

    property p_disabled_quiet;
        (power_request_n && (wake_set & wake_enable) == '0) |=> power_request_n;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("power requested without enable");

    property p_status_reset;
        $rose(aresetn) |-> status == wsod_pkg::WAKE_STATUS_RESET;
    endproperty
    a_status_reset: assert property (p_status_reset) else $error("status not zero after reset");

    property p_delay_reset;
        $rose(aresetn) |-> delay_reg == wsod_pkg::OFF_DELAY_RESET && delay_reg[7:6] == 2'h0;
    endproperty
    a_delay_reset: assert property (p_delay_reset) else $error("delay not zero after reset");

    property p_off_en_reset;
        $rose(aresetn) |-> enable_two == wsod_pkg::ENABLE_TWO_RESET;
    endproperty
    a_off_en_reset: assert property (p_off_en_reset) else $error("enable two reset wrong");

    property p_start_gated;
        $rose(timer_busy) |-> $past(button_edge && enable_two[wsod_pkg::BIT_OFF_EN] && delayed_off_select);
    endproperty
    a_start_gated: assert property (p_start_gated) else $error("delay started without gate");

    property p_expiry_releases;
        (timer_expired && !wake_hit) |=> power_request_n;
    endproperty
    a_expiry_releases: assert property (p_expiry_releases) else $error("expiry kept power on");
endmodule // wsod_top
`default_nettype wire

// ---- shared/wsod_pkg.sv ----
// constants and types shared by the wake status and off-delay block
package wsod_pkg;
    // bus geometry: register index sits in address bits [9:2]
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_ENABLE_TWO = 8'hb1;
    localparam logic [7:0] IDX_WAKE_STATUS_TWO = 8'hb3;
    localparam logic [7:0] IDX_OFF_DELAY = 8'hb8;
    localparam logic [7:0] IDX_CONTROL = 8'hc8;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hc9;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hca;

    // reset values and writable-bit masks
    localparam logic [7:0] ENABLE_TWO_RESET = 8'h80;
    localparam logic [7:0] ENABLE_TWO_MASK = 8'hab;
    localparam logic [7:0] WAKE_STATUS_RESET = 8'h00;
    localparam logic [7:0] OFF_DELAY_RESET = 8'h00;
    localparam logic [7:0] OFF_DELAY_MASK = 8'h3f;

    // bit positions in the enable layout, shared with the status layout except the off-allow bit 7
    localparam int BIT_RX_FIRST = 0;
    localparam int BIT_RX_SECOND = 1;
    localparam int BIT_RING = 3;
    localparam int BIT_INFRARED = 5;
    localparam int BIT_OFF_EN = 7;
    localparam int WAKE_N = 4;
    localparam int DELAY_CODE_W = 6;

    // control register bits
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_POWER_BIT = 1;
    localparam int CTRL_BUSY_BIT = 2;

    // interrupt layout
    localparam int IRQ_W = 2;
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_EXPIRE_BIT = 1;

    // timing: one delay step in ms times the clock in kHz gives cycles
    localparam int CLK_KHZ = 40_000;
    localparam int DELAY_STEP_MS = 500;
    localparam int DELAY_STEP_CYCLES = DELAY_STEP_MS * CLK_KHZ;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic cir_wake_event;
        logic ring_indicator_pin_n;
        logic uart_second_rx;
        logic uart_first_rx;
    } wsod_pins_t;

    typedef struct packed {
        logic [1:0] reserved_hi;
        logic infrared_wake_flag;
        logic reserved_four;
        logic ring_wake_flag;
        logic reserved_two;
        logic uart_second_rx_wake_flag;
        logic uart_first_rx_wake_flag;
    } wsod_status_t;
endpackage

// ---- core/wsod_edge_latch.sv ----
// falling-edge catchers with sticky flags, one per wake source
`timescale 1ns/1ps
`default_nettype none
module wsod_edge_latch #(
    parameter int N = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] level_n,
    input wire logic [N-1:0] clear,
    output logic [N-1:0] set_pulse,
    output logic [N-1:0] flag
);
    if (N < 1) begin : g_check
        $error("wsod_edge_latch needs at least one input");
    end

    for (genvar i = 0; i < N; i++) begin : g_bit
        logic prev;
        logic held;
        // idle-high lines: a fall is previous high, present low
        assign set_pulse[i] = prev & ~level_n[i];
        assign flag[i] = held;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                prev <= 1'b1;
                held <= 1'b0;
            end else begin
                prev <= level_n[i];
                // an event in the clearing cycle is kept
                if (set_pulse[i]) begin
                    held <= 1'b1;
                end else if (clear[i]) begin
                    held <= 1'b0;
                end
            end
        end
    end
endmodule // wsod_edge_latch
`default_nettype wire

// ---- core/wsod_delay_timer.sv ----
// power-off delay counter in whole steps of the step period
`timescale 1ns/1ps
`default_nettype none
module wsod_delay_timer #(
    parameter int CODE_W = wsod_pkg::DELAY_CODE_W,
    parameter int STEP_CYCLES = wsod_pkg::DELAY_STEP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [CODE_W-1:0] code,
    output logic busy,
    output logic expired
);
    localparam int STEP_W = $clog2(STEP_CYCLES);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

    if (STEP_CYCLES < 2 || CODE_W < 1) begin : g_check
        $error("wsod_delay_timer needs STEP_CYCLES >= 2 and CODE_W >= 1");
    end

    logic [STEP_W-1:0] step_cnt;
    logic [CODE_W-1:0] steps;
    logic [CODE_W-1:0] target;

    // code is latched at start so a rewrite mid-delay cannot stretch it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            expired <= 1'b0;
            step_cnt <= '0;
            steps <= '0;
            target <= '0;
        end else begin
            expired <= 1'b0;
            if (!busy) begin
                if (start) begin
                    busy <= 1'b1;
                    target <= code;
                    step_cnt <= '0;
                    steps <= '0;
                end
            end else if (step_cnt == STEP_LAST) begin
                step_cnt <= '0;
                if (steps == target) begin
                    busy <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    steps <= steps + 1'b1;
                end
            end else begin
                step_cnt <= step_cnt + 1'b1;
            end
        end
    end

    logic [31:0] elapsed;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            elapsed <= 32'h0;
        end else if (!busy) begin
            elapsed <= 32'h0;
        end else begin
            elapsed <= elapsed + 32'h1;
        end
    end

    property p_expire_span;
        @(posedge aclk) disable iff (!aresetn)
        expired |-> elapsed == (32'(target) + 32'h1) * 32'(STEP_CYCLES);
    endproperty
    a_expire_span: assert property (p_expire_span) else $error("delay length wrong");
endmodule // wsod_delay_timer
`default_nettype wire

// ---- testbench/wsod_wake_src.sv ----
// wake source pins and power button driven for the bench
`timescale 1ns/1ps
`default_nettype none
module wsod_wake_src (
    input wire logic aclk,
    output var wsod_pkg::wsod_pins_t wake_pins,
    output var logic button_in
);
    // idle: receive lines and ring line high, infrared low
    localparam logic [3:0] IDLE = 4'h7;
    initial begin
        wake_pins = IDLE;
        button_in = 1'b0;
    end
    // one-cycle active level on pin p, then idle again
    task automatic fire(input int p);
        wake_pins <= IDLE ^ (4'h1 << p);
        @(posedge aclk);
        wake_pins <= IDLE;
    endtask
    task automatic press();
        button_in <= 1'b1;
        @(posedge aclk);
        button_in <= 1'b0;
    endtask
endmodule // wsod_wake_src
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the wake status and off-delay block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [7:0] idx; logic [31:0] d; logic [1:0] r;} wsod_row_t;
    localparam int S = 4;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [9:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = '0, rdata;
    logic awready, wready, bvalid, arready, rvalid, power_request_n, irq, button_in;
    logic [1:0] bresp, rresp, r;
    logic [31:0] d;
    wsod_pkg::wsod_pins_t wake_pins;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    int sb[4] = '{0, 1, 3, 5};
    int pn[4] = '{0, 1, 2, 3};
    wsod_row_t rows[6] = '{
        '{wsod_pkg::IDX_ENABLE_TWO, 32'h80, 2'h0}, '{wsod_pkg::IDX_WAKE_STATUS_TWO, 32'h0, 2'h0},
        '{wsod_pkg::IDX_OFF_DELAY, 32'h0, 2'h0}, '{wsod_pkg::IDX_CONTROL, 32'h0, 2'h0},
        '{wsod_pkg::IDX_IRQ_MASK, 32'h0, 2'h0}, '{8'hff, 32'h0, 2'h2}};
    always #12.5 aclk = ~aclk;
    wsod_top #(.STEP_CYCLES(S)) wsod_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wake_pins(wake_pins), .button_in(button_in), .power_request_n(power_request_n), .irq(irq));
    wsod_wake_src wsod_wake_src_inst (.aclk(aclk), .wake_pins(wake_pins), .button_in(button_in));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // byte address is four times the index; ready/response readies stay high
    task automatic wr(input logic [7:0] i, input logic [7:0] v, output logic [1:0] rs);
        logic ga, gw;
        ga = 1'b0;
        gw = 1'b0;
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge aclk);
            if (awready && !ga) begin
                ga = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !gw) begin
                gw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
    endtask
    task automatic rd(input logic [7:0] i, output logic [31:0] v, output logic [1:0] rs);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(power_request_n, 1'b1);
        foreach (rows[k]) begin
            rd(rows[k].idx, d, r);
            chk(d, rows[k].d);
            chk(r, rows[k].r);
        end
        wr(wsod_pkg::IDX_OFF_DELAY, 8'hff, r);
        chk(r, 32'h0);
        wr(8'hff, 8'h00, r);
        chk(r, 32'h2);
        rd(wsod_pkg::IDX_OFF_DELAY, d, r);
        chk(d, 32'h3f);
        // disabled events: flag latches, power stays off
        for (int k = 0; k < 4; k++) begin
            wsod_wake_src_inst.fire(pn[k]);
            repeat (2) @(posedge aclk);
            rd(wsod_pkg::IDX_WAKE_STATUS_TWO, d, r);
            chk(d, 32'h1 << sb[k]);
            chk(power_request_n, 1'b1);
            rd(wsod_pkg::IDX_WAKE_STATUS_TWO, d, r);
            chk(d, 32'h0);
        end
        wr(wsod_pkg::IDX_IRQ_MASK, 8'h01, r);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        wr(wsod_pkg::IDX_IRQ_STATUS, 8'h01, r);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(wsod_pkg::IDX_ENABLE_TWO, 8'hab, r);
        wsod_wake_src_inst.fire(pn[3]);
        repeat (2) @(posedge aclk);
        chk(power_request_n, 1'b0);
        chk(irq, 1'b1);
        // press with delayed-off clear must not start the delay
        wr(wsod_pkg::IDX_OFF_DELAY, 8'h01, r);
        wsod_wake_src_inst.press();
        repeat (20) @(posedge aclk);
        chk(power_request_n, 1'b0);
        wr(wsod_pkg::IDX_CONTROL, 8'h01, r);
        wsod_wake_src_inst.press();
        // start is taken at the press edge; the release lands (code+1)*S+1 edges later
        repeat (2 * S + 1) @(posedge aclk);
        chk(power_request_n, 1'b0);
        @(posedge aclk);
        chk(power_request_n, 1'b1);
        rd(wsod_pkg::IDX_IRQ_STATUS, d, r);
        chk(d, 32'h3);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
